// File: src/hlv_consts.vh
// offsets, field values, reset values for the hub link vc register block
`ifndef HLV_CONSTS_VH
`define HLV_CONSTS_VH

// byte offsets of the registers inside the block
`define HLV_OFF_CAP_HDR 8'h00
`define HLV_OFF_PVC_CAP1 8'h04
`define HLV_OFF_PVC_CAP2 8'h08
`define HLV_OFF_PVC_CTL 8'h0c
`define HLV_OFF_VC0_RCAP 8'h10
`define HLV_OFF_VC0_RCTL 8'h14
`define HLV_OFF_VC0_RSTS 8'h1a
`define HLV_OFF_VC1_RCAP 8'h1c
`define HLV_OFF_VC1_RCTL 8'h20
`define HLV_OFF_VC1_RSTS 8'h26
`define HLV_OFF_LINK_CAP 8'h84
`define HLV_OFF_LINK_CTL 8'h88
`define HLV_OFF_LINK_STS 8'h8a

// reset values
`define HLV_RST_CAP_HDR 32'h04010002
`define HLV_RST_PVC_CAP1 32'h00000001
`define HLV_RST_PVC_CAP2 32'h00000000
`define HLV_RST_PVC_CTL 16'h0000
`define HLV_RST_VC0_RCAP 32'h00000001
`define HLV_RST_VC0_RCTL 32'h800000ff
`define HLV_RST_VC0_RSTS 16'h0002
`define HLV_RST_VC1_RCAP 32'h00008001
`define HLV_RST_VC1_RCTL 32'h01000000
`define HLV_RST_VC1_RSTS 16'h0002
`define HLV_RST_LINK_CAP 32'h00012c41
`define HLV_RST_LINK_CTL 16'h0000
`define HLV_RST_LINK_STS 16'h0001

// capability header fields
`define HLV_NEXT_CAP_PTR 12'h040
`define HLV_CAP_VERSION 4'h1
`define HLV_EXT_CAP_ID 16'h0002

// port vc capability one fields
`define HLV_LOW_PRIO_COUNT 3'h0
`define HLV_EXTRA_COUNT_RST 3'h1

// size of the decoded window, in address bits below the base
`define HLV_WINDOW_BITS 12

`endif

// File: src/hlv_write_once.v
// a field that takes only the first software write after reset
`timescale 1ns/1ps
module hlv_write_once #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire sys_clk,
    input wire rst,
    input wire wrEn,
    input wire [WIDTH-1:0] wrData,
    output reg [WIDTH-1:0] value_q,
    output reg locked_q
);

////////////////////////////////////////////////////////////////////////
// first write stores and locks, later writes fall away until reset
always @(posedge sys_clk) begin
    if (rst) begin
        value_q <= RESET_VALUE;
        locked_q <= 1'b0;
    end else if (wrEn && !locked_q) begin
        value_q <= wrData;
        locked_q <= 1'b1;
    end
end

endmodule // hlv_write_once

// File: src/hlv_regs.v
// memory-mapped virtual channel capability registers of the hub link
// What this block does
// - decode block at base from configuration space
// - header bits 31:20 read next pointer 040h
// - header bits 19:16 hardwired to version 1
// - header bits 15:0 read capability id 0002h
// - low priority channel count reads 000b
// - extra channel count write-once, resets to 001b
// - reported count excludes the private channel
// - vc0 resource control at 14h, reset 800000ffh
`timescale 1ns/1ps
`include "hlv_consts.vh"
module hlv_regs (
    input wire sys_clk,
    input wire rst,
    input wire [31:12] blockBase,
    input wire blockEnable,
    input wire reqValid,
    input wire reqWrite,
    input wire [31:0] reqAddr,
    input wire [3:0] reqByteEn,
    input wire [31:0] reqWrData,
    output reg ackValid_q,
    output reg [31:0] rdData_q,
    output reg [2:0] extraChannelCount_q,
    output reg extraCountLocked_q,
    output reg [2:0] vcArbSelect_q,
    output reg [2:0] vc0PortArbSelect_q,
    output reg [7:0] vc0TcMap_q,
    output reg vc1Enable_q,
    output reg [2:0] vc1Id_q,
    output reg [7:0] vc1TcMap_q,
    output reg [1:0] linkPowerCtl_q
);

////////////////////////////////////////////////////////////////////////
// address decode

// request lands inside the block window
wire inWindow;
// dword offset inside the block, low two bits dropped
wire [7:0] dwOff;
// write strobe for an accepted write
wire wrHit;
// per-lane write enables
wire [3:0] laneWr;

assign inWindow = blockEnable &&
    (reqAddr[31:`HLV_WINDOW_BITS] == blockBase);
assign dwOff = {reqAddr[7:2], 2'b00};
assign wrHit = reqValid && reqWrite && inWindow &&
    (reqAddr[`HLV_WINDOW_BITS-1:8] == 4'h0);
assign laneWr = wrHit ? reqByteEn : 4'h0;

////////////////////////////////////////////////////////////////////////
// write-once extra channel count

// selects the port vc capability one dword for writing
wire selCap1;
// stored count from the write-once cell
wire [2:0] countValue;
// lock flag from the write-once cell
wire countLocked;

assign selCap1 = (dwOff == `HLV_OFF_PVC_CAP1);

// private channel never counted, software sets the count
hlv_write_once #(
    .WIDTH(3),
    .RESET_VALUE(`HLV_EXTRA_COUNT_RST)
) uCount (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(selCap1 && laneWr[0]),
    .wrData(reqWrData[2:0]),
    .value_q(countValue),
    .locked_q(countLocked)
);

////////////////////////////////////////////////////////////////////////
// reset images of the mixed registers, sliced per field below

// port vc control image
wire [15:0] pvcCtlRst;
// vc0 resource control image
wire [31:0] vc0CtlRst;
// vc1 resource control image
wire [31:0] vc1CtlRst;

// slicing keeps every field at its own width, nothing cut by accident
assign pvcCtlRst = `HLV_RST_PVC_CTL;
assign vc0CtlRst = `HLV_RST_VC0_RCTL;
assign vc1CtlRst = `HLV_RST_VC1_RCTL;

////////////////////////////////////////////////////////////////////////
// software writable control fields

// mirror of the write-once cell as registered outputs
always @(posedge sys_clk) begin
    if (rst) begin
        extraChannelCount_q <= `HLV_EXTRA_COUNT_RST;
        extraCountLocked_q <= 1'b0;
    end else begin
        extraChannelCount_q <= countValue;
        extraCountLocked_q <= countLocked;
    end
end

// read-write fields; read-only bits around them take no write
always @(posedge sys_clk) begin
    if (rst) begin
        vcArbSelect_q <= pvcCtlRst[3:1];
        vc0PortArbSelect_q <= vc0CtlRst[19:17];
        vc0TcMap_q <= vc0CtlRst[7:0];
        vc1Enable_q <= vc1CtlRst[31];
        vc1Id_q <= vc1CtlRst[26:24];
        vc1TcMap_q <= vc1CtlRst[7:0];
        linkPowerCtl_q <= 2'h0;
    end else begin
        // port vc control, arbitration select bits 3:1
        if (dwOff == `HLV_OFF_PVC_CTL && laneWr[0]) begin
            vcArbSelect_q <= reqWrData[3:1];
        end
        // vc0 control, bit 0 of the map stays 1 and read-only
        if (dwOff == `HLV_OFF_VC0_RCTL) begin
            if (laneWr[2]) begin
                vc0PortArbSelect_q <= reqWrData[19:17];
            end
            if (laneWr[0]) begin
                vc0TcMap_q <= {reqWrData[7:1], 1'b1};
            end
        end
        // vc1 control, enable, id and map
        if (dwOff == `HLV_OFF_VC1_RCTL) begin
            if (laneWr[3]) begin
                vc1Enable_q <= reqWrData[31];
                vc1Id_q <= reqWrData[26:24];
            end
            if (laneWr[0]) begin
                vc1TcMap_q <= {reqWrData[7:1], 1'b0};
            end
        end
        // link control, low power control bits
        if (dwOff == `HLV_OFF_LINK_CTL && laneWr[0]) begin
            linkPowerCtl_q <= reqWrData[1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// read mux

// assembled read word for the addressed dword
reg [31:0] rdWord;

always @* begin
    rdWord = 32'h00000000;
    if (reqAddr[`HLV_WINDOW_BITS-1:8] == 4'h0) begin
        case (dwOff)
            `HLV_OFF_CAP_HDR: begin
                rdWord = {`HLV_NEXT_CAP_PTR,
                    `HLV_CAP_VERSION,
                    `HLV_EXT_CAP_ID};
            end
            `HLV_OFF_PVC_CAP1: begin
                rdWord = {25'h0000000, `HLV_LOW_PRIO_COUNT,
                    1'b0, countValue};
            end
            `HLV_OFF_PVC_CAP2: begin
                rdWord = `HLV_RST_PVC_CAP2;
            end
            `HLV_OFF_PVC_CTL: begin
                rdWord = {28'h0000000, vcArbSelect_q, 1'b0};
            end
            `HLV_OFF_VC0_RCAP: begin
                rdWord = `HLV_RST_VC0_RCAP;
            end
            `HLV_OFF_VC0_RCTL: begin
                // enable hardwired, id hardwired zero
                rdWord = {vc0CtlRst[31], 11'h000,
                    vc0PortArbSelect_q, 9'h000, vc0TcMap_q};
            end
            8'h18: begin
                // status sits in the upper half of this dword
                rdWord = {`HLV_RST_VC0_RSTS, 16'h0000};
            end
            `HLV_OFF_VC1_RCAP: begin
                rdWord = `HLV_RST_VC1_RCAP;
            end
            `HLV_OFF_VC1_RCTL: begin
                rdWord = {vc1Enable_q, 4'h0, vc1Id_q, 16'h0000,
                    vc1TcMap_q};
            end
            8'h24: begin
                rdWord = {`HLV_RST_VC1_RSTS, 16'h0000};
            end
            `HLV_OFF_LINK_CAP: begin
                rdWord = `HLV_RST_LINK_CAP;
            end
            `HLV_OFF_LINK_CTL: begin
                // control low half, status high half
                rdWord = {`HLV_RST_LINK_STS, 14'h0000, linkPowerCtl_q};
            end
            default: begin
                // unmapped offsets read zero
                rdWord = 32'h00000000;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// answer register: one cycle after a request in the window

always @(posedge sys_clk) begin
    if (rst) begin
        ackValid_q <= 1'b0;
        rdData_q <= 32'h00000000;
    end else begin
        ackValid_q <= reqValid && inWindow;
        if (reqValid && inWindow && !reqWrite) begin
            rdData_q <= rdWord;
        end
    end
end

endmodule // hlv_regs

// File: tb/hlv_regs_sva.sv
// checker for the hub link vc register block
`timescale 1ns/1ps
module hlv_regs_sva (
    input wire sys_clk,
    input wire rst,
    input wire [31:12] blockBase,
    input wire blockEnable,
    input wire reqValid,
    input wire reqWrite,
    input wire [31:0] reqAddr,
    input wire ackValid_q,
    input wire [31:0] rdData_q,
    input wire [2:0] extraChannelCount_q,
    input wire extraCountLocked_q
);
    // request that lands inside the decoded window
    wire hit = reqValid && blockEnable && reqAddr[31:12] == blockBase;
    wire rdHit = hit && !reqWrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ack_on_hit: assert property (hit |=> ackValid_q)
        else $error("missing ack");
    a_no_stray: assert property (!hit |=> !ackValid_q)
        else $error("ack outside window");
    a_next_ptr: assert property (rdHit && reqAddr[11:2] == 10'h0
        |=> rdData_q[31:20] == 12'h040) else $error("bad next pointer");
    a_cap_ver: assert property (rdHit && reqAddr[11:2] == 10'h0
        |=> rdData_q[19:16] == 4'h1) else $error("bad version");
    a_cap_id: assert property (rdHit && reqAddr[11:2] == 10'h0
        |=> rdData_q[15:0] == 16'h0002) else $error("bad capability id");
    a_low_prio: assert property (rdHit && reqAddr[11:2] == 10'h1
        |=> rdData_q[6:4] == 3'h0) else $error("bad low priority count");
    a_count_reset: assert property (!extraCountLocked_q
        |-> extraChannelCount_q == 3'h1) else $error("bad count default");
    a_count_frozen: assert property (extraCountLocked_q
        |=> $stable(extraChannelCount_q)) else $error("count rewritten");
    a_vc0_on: assert property (rdHit && reqAddr[11:2] == 10'h5
        |=> rdData_q[31] && rdData_q[26:24] == 3'h0) else $error("bad vc0");
    c_lock: cover property ($rose(extraCountLocked_q));
    c_read: cover property (rdHit ##1 ackValid_q);
    c_miss: cover property (reqValid && !blockEnable);
endmodule // hlv_regs_sva
bind hlv_regs hlv_regs_sva u_sva (.sys_clk(sys_clk), .rst(rst),
    .blockBase(blockBase), .blockEnable(blockEnable), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .ackValid_q(ackValid_q),
    .rdData_q(rdData_q), .extraChannelCount_q(extraChannelCount_q),
    .extraCountLocked_q(extraCountLocked_q));

// File: tb/hlv_regs_bench.sv
// self-checking bench for the hub link vc register block
`timescale 1ns/1ps
module hlv_regs_bench;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg [31:12] blockBase = 20'hfed18;
    reg blockEnable = 1'b1;
    reg reqValid = 1'b0;
    reg reqWrite = 1'b0;
    reg [31:0] reqAddr = 32'h0;
    reg [3:0] reqByteEn = 4'h0;
    reg [31:0] reqWrData = 32'h0;
    wire ackValid_q;
    wire [31:0] rdData_q;
    wire [2:0] cnt;
    wire locked;
    wire [7:0] tcMap0;
    wire [2:0] vcArbSel;
    wire [2:0] vc0PortArb;
    wire vc1En;
    wire [2:0] vc1IdOut;
    wire [7:0] tcMap1;
    wire [1:0] linkPwr;
    integer mismatches = 0;
    integer n_checks = 0;
    integer i;
    // dword offsets and their reset images, 16-bit pairs merged
    localparam [95:0] OFFS = 96'h000408_0c1014_181c20_248488;
    localparam [383:0] EXPS = {32'h04010002, 32'h1, 32'h0, 32'h0, 32'h1,
        32'h800000ff, 32'h00020000, 32'h8001, 32'h01000000, 32'h00020000,
        32'h00012c41, 32'h00010000};
    hlv_regs DUT (.sys_clk(sys_clk), .rst(rst), .blockBase(blockBase),
        .blockEnable(blockEnable), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqByteEn(reqByteEn), .reqWrData(reqWrData),
        .ackValid_q(ackValid_q), .rdData_q(rdData_q),
        .extraChannelCount_q(cnt), .extraCountLocked_q(locked),
        .vcArbSelect_q(vcArbSel), .vc0PortArbSelect_q(vc0PortArb),
        .vc0TcMap_q(tcMap0), .vc1Enable_q(vc1En), .vc1Id_q(vc1IdOut),
        .vc1TcMap_q(tcMap1), .linkPowerCtl_q(linkPwr));
    // free running clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task stop_test;
        begin
            if (mismatches == 0 && n_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // one request held over its taking edge; answer stands on return
    task xfer(input wr, input [31:0] a, input [3:0] be, input [31:0] d);
        begin
            @(negedge sys_clk);
            reqValid = 1'b1;
            reqWrite = wr;
            reqAddr = a;
            reqByteEn = be;
            reqWrData = d;
            @(negedge sys_clk);
            reqValid = 1'b0;
        end
    endtask
    task rd(input [11:0] off, input [31:0] exp);
        begin
            xfer(1'b0, {blockBase, off}, 4'hf, 32'h0);
            chk({31'h0, ackValid_q}, 32'h1);
            chk(rdData_q, exp);
        end
    endtask
    task t_reset_map;
        begin
            for (i = 0; i < 12; i = i + 1)
                rd({4'h0, OFFS[95-8*i -: 8]}, EXPS[383-32*i -: 32]);
            rd(12'h030, 32'h0);
        end
    endtask
    task t_write_once;
        begin
            xfer(1'b1, {blockBase, 12'h104}, 4'h1, 32'h6);
            rd(12'h104, 32'h0);
            rd(12'h004, 32'h1);
            chk({31'h0, locked}, 32'h0);
            xfer(1'b1, {blockBase, 12'h004}, 4'h1, 32'h73);
            rd(12'h004, 32'h3);
            chk({29'h0, cnt}, 32'h3);
            chk({31'h0, locked}, 32'h1);
            xfer(1'b1, {blockBase, 12'h004}, 4'h1, 32'h5);
            rd(12'h004, 32'h3);
        end
    endtask
    task t_read_only;
        begin
            xfer(1'b1, {blockBase, 12'h000}, 4'hf, 32'hffffffff);
            rd(12'h000, 32'h04010002);
            xfer(1'b1, {blockBase, 12'h014}, 4'hf, 32'hffffffff);
            rd(12'h014, 32'h800e00ff);
            chk({24'h0, tcMap0}, 32'hff);
            xfer(1'b1, {blockBase, 12'h014}, 4'h1, 32'h0);
            rd(12'h014, 32'h800e0001);
            chk({21'h0, vc0PortArb, tcMap0}, 32'h00000701);
        end
    endtask
    task t_control_fields;
        begin
            xfer(1'b1, {blockBase, 12'h00c}, 4'h1, 32'hffffffff);
            rd(12'h00c, 32'h0000000e);
            chk({29'h0, vcArbSel}, 32'h7);
            xfer(1'b1, {blockBase, 12'h020}, 4'hf, 32'hffffffff);
            chk(rdData_q, 32'h0000000e);
            rd(12'h020, 32'h870000fe);
            chk({vc1En, 20'h0, vc1IdOut, tcMap1}, 32'h800007fe);
            xfer(1'b1, {blockBase, 12'h088}, 4'hf, 32'hffffffff);
            rd(12'h088, 32'h00010003);
            chk({30'h0, linkPwr}, 32'h3);
            xfer(1'b1, {blockBase, 12'h084}, 4'hf, 32'hffffffff);
            rd(12'h084, 32'h00012c41);
        end
    endtask
    task t_window;
        begin
            @(negedge sys_clk);
            blockEnable = 1'b0;
            xfer(1'b0, {blockBase, 12'h000}, 4'hf, 32'h0);
            chk({31'h0, ackValid_q}, 32'h0);
            blockEnable = 1'b1;
            xfer(1'b0, {blockBase ^ 20'h1, 12'h000}, 4'hf, 32'h0);
            chk({31'h0, ackValid_q}, 32'h0);
        end
    endtask
    task t_second_reset;
        begin
            @(negedge sys_clk);
            rst = 1'b1;
            @(negedge sys_clk);
            rst = 1'b0;
            rd(12'h004, 32'h1);
            chk({31'h0, locked}, 32'h0);
            chk({21'h0, vc0PortArb, tcMap0}, 32'h000000ff);
            chk({vc1En, 20'h0, vc1IdOut, tcMap1}, 32'h00000100);
            chk({27'h0, vcArbSel, linkPwr}, 32'h0);
        end
    endtask
    // watchdog against a hung run
    initial begin
        #100000;
        mismatches = mismatches + 1;
        stop_test;
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        t_reset_map;
        t_write_once;
        t_read_only;
        t_control_fields;
        t_window;
        t_second_reset;
        stop_test;
    end
endmodule // hlv_regs_bench
